// ### verif/afc_frontend_ctrl_checker.sv
// checker for the converter front-end control block
`timescale 1ns/10ps
`include "afc_defs.vh"
module afc_frontend_ctrl_checker (
	input wire logic       mclk,
	input wire logic       sys_rst,
	input wire logic       oscClk,
	input wire logic       modulatorRate,
	input wire logic [2:0] effGainCode,
	input wire logic       ampEnable,
	input wire logic       ampRouteAround,
	input wire logic [2:0] scapGainCode,
	input wire logic       scapBufEnable,
	input wire logic [1:0] refSelect,
	input wire logic       refBufEnable,
	input wire logic       refSettled,
	input wire logic       sampleValid
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic        oscPrev_r;
	logic        modPrev_r;
	logic        modSeen_r;
	logic [3:0]  oscCnt_r;
	logic [10:0] cyc_r;
	wire         oscRise = oscClk & ~oscPrev_r;
	wire         modRise = modulatorRate & ~modPrev_r;
	// first modulator edge after reset has no full period behind it
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			oscPrev_r <= 1'b0;
			modPrev_r <= 1'b0;
			modSeen_r <= 1'b0;
			oscCnt_r  <= 4'h0;
			cyc_r     <= 11'h000;
		end else begin
			oscPrev_r <= oscClk;
			modPrev_r <= modulatorRate;
			if (cyc_r != 11'h7FF)
				cyc_r <= cyc_r + 11'h001;
			if (modRise) begin
				oscCnt_r  <= 4'h0;
				modSeen_r <= 1'b1;
			end else if (oscRise && oscCnt_r != 4'hF)
				oscCnt_r <= oscCnt_r + 4'h1;
		end
	end
	a_scap_buf_inv: assert property (scapBufEnable == !ampEnable)
		else $error("scap buffer not inverse of amp enable");
	a_bypass_amp_off: assert property (ampRouteAround |-> !ampEnable)
		else $error("amp on while routed around");
	a_forced_gain_cap: assert property (ampRouteAround |-> effGainCode <= `AFC_GAIN4)
		else $error("gain above 4 while bypassed");
	a_scap_gain_split: assert property (scapGainCode ==
		(effGainCode > `AFC_GAIN4 ? `AFC_GAIN4 : effGainCode))
		else $error("scap gain split wrong");
	a_high_gain_amp: assert property (effGainCode > `AFC_GAIN4 |-> ampEnable)
		else $error("high gain without amp");
	a_ref_buf_ext: assert property (refBufEnable == (refSelect == `AFC_REF_EXT))
		else $error("ref buffer enable wrong");
	a_mod_quarter: assert property (modRise && modSeen_r |-> oscCnt_r + oscRise == 4)
		else $error("modulator not osc over four");
	a_ref_settle_by: assert property (cyc_r == 11'h3F2 |-> refSettled)
		else $error("reference not settled in time");
	a_sample_pulse: assert property (sampleValid |=> !sampleValid)
		else $error("sample valid longer than one cycle");
endmodule // afc_frontend_ctrl_checker
bind afc_frontend_ctrl afc_frontend_ctrl_checker chk_u (.mclk, .sys_rst, .oscClk, .modulatorRate,
	.effGainCode, .ampEnable, .ampRouteAround, .scapGainCode, .scapBufEnable, .refSelect,
	.refBufEnable, .refSettled, .sampleValid);

// ### verif/afc_frontend_ctrl_tb_top.sv
// self-checking testbench for the front-end control block
`timescale 1ns/10ps
`include "afc_defs.vh"
module afc_frontend_ctrl_tb_top;
	logic        mclk, sys_rst, modBit;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, v;
	logic [1:0]  r;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp, refSelect;
	wire  [31:0] s_axi_rdata;
	wire         oscClk, modulatorRate, ampEnable, ampRouteAround, scapBufEnable;
	wire         refBufEnable, refSettled, sampleValid;
	wire  [2:0]  effGainCode, scapGainCode;
	wire  [15:0] sampleData;
	logic        oscP, modP;
	int          n_errors = 0, n_tests = 0, oscN = 0, modN = 0, n0, m0, g, b, f, by, e;
	logic [3:0]  rts [4] = '{4'h7, 4'h8, 4'hB, 4'hC};
	afc_frontend_ctrl dut_u (.*);
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		oscP <= oscClk;
		modP <= modulatorRate;
		if (oscClk && !oscP) oscN <= oscN + 1;
		if (modulatorRate && !modP) modN <= modN + 1;
	end
	task results;
		if (n_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_tests++;
		if (got !== ex) begin
			$display("BAD %s exp %h got %h", nm, ex, got);
			n_errors++;
		end
	endtask
	// bready held from the offer so the answer is taken at its first edge
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		s_axi_rready <= 1'b0;
	endtask
	task waitS;
		do @(posedge mclk); while (sampleValid !== 1'b1);
	endtask
	initial begin
		#1000000;
		n_errors++;
		results();
	end
	initial begin
		sys_rst <= 1'b1;
		modBit <= 1'b0;
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b0;
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b0;
		s_axi_awaddr <= 4'h0;
		s_axi_araddr <= 4'h0;
		s_axi_wdata <= 32'h0000_0000;
		s_axi_wstrb <= 4'hF;
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		chk("settle0", 0, refSettled);
		rd(`AFC_ADDR_CFG);
		chk("cfgRst", `AFC_CFG_RST, v);
		chk("refRst", `AFC_REF_INT, refSelect);
		rd(`AFC_ADDR_RATE);
		chk("rateRst", `AFC_DEC_RST, v);
		repeat (1010) @(posedge mclk);
		chk("settle1", 1, refSettled);
		for (int i = 0; i < 64; i++) begin
			g = i % 8;
			b = (i / 8) % 2;
			f = (rts[i / 16] >= 4'h8 && rts[i / 16] <= 4'hB);
			by = f || (b && g <= 2);
			e = (f && g > 2) ? 2 : g;
			wr(`AFC_ADDR_CFG, (rts[i / 16] << 4) | (b << 3) | g);
			chk("effGain", e, effGainCode);
			chk("ampEn", !by, ampEnable);
			chk("bypass", by, ampRouteAround);
			chk("scapGain", (e > 2) ? 2 : e, scapGainCode);
			chk("scapBuf", by, scapBufEnable);
		end
		// ending on internal makes the last step a switch back from external
		for (int i = 3; i >= 0; i--) begin
			wr(`AFC_ADDR_CFG, i << 8);
			chk("refSel", i, refSelect);
			chk("refBuf", i == 1, refBufEnable);
		end
		repeat (2) @(posedge mclk);
		chk("settleSw0", 0, refSettled);
		repeat (1010) @(posedge mclk);
		chk("settleSw1", 1, refSettled);
		wr(`AFC_ADDR_STAT, 32'hFFFF_FFFF);
		chk("statResp", 2'h2, r);
		wr(`AFC_ADDR_RATE, 32'h0000_0000);
		rd(`AFC_ADDR_RATE);
		chk("rateKeep", `AFC_DEC_RST, v);
		for (int t = 0; t < 2; t++) begin
			wr(`AFC_ADDR_CFG, t << 10);
			n0 = oscN;
			m0 = modN;
			e = 100 * (t + 1);
			repeat (3906) @(posedge mclk);
			chk("oscRate", 1, oscN - n0 >= e - 1 && oscN - n0 <= e + 1);
			chk("modRate", 1, modN - m0 >= e / 4 - 1 && modN - m0 <= e / 4 + 1);
		end
		modBit <= 1'b1;
		wr(`AFC_ADDR_RATE, 32'h0000_0004);
		waitS();
		waitS();
		chk("sumOnes", 4, sampleData);
		rd(`AFC_ADDR_DATA);
		chk("dataReg", 4, v);
		modBit <= 1'b0;
		waitS();
		waitS();
		chk("sumZero", 0, sampleData);
		results();
	end
endmodule // afc_frontend_ctrl_tb_top

// ### verilog/afc_defs.vh
// constants and register map for the converter front-end control block
// Behaviour
// - bypass flag with gain 1, 2 or 4 powers down amplifier and routes around it
// - routes 1000..1011 tie negative input to supply; amplifier always bypassed there
// - under forced bypass any gain above 4 is applied as 4
// - amplifier off: gains 1, 2, 4 come from buffered switched-capacitor stage
// - two-bit field picks internal 2.048 V, external pair or analog supply reference
// - reference selection resets to internal reference
// - internal reference settled within 25 us after power-up, wake or switch-back
// - external reference selection enables reference input buffers
// - modulator clock is oscillator divided by four
// - normal mode: oscillator 1.024 MHz, modulator 256 kHz
// - turbo mode: oscillator 2.048 MHz, modulator 512 kHz
// - linear-phase FIR filters and decimates modulator bitstream into samples
// - filter follows data rate; every output settled after one conversion
// - data rate and notches scale with oscillator clock
// - three-bit gain code selects 1..128; above 4 also uses amplifier
// - four-bit route field selects inputs, some tie negative input to supply
`ifndef AFC_DEFS_VH
`define AFC_DEFS_VH
`define AFC_ADDR_CFG     4'h0
`define AFC_ADDR_RATE    4'h4
`define AFC_ADDR_STAT    4'h8
`define AFC_ADDR_DATA    4'hC
`define AFC_GAIN_LSB     0
`define AFC_GAIN_MSB     2
`define AFC_BYP_BIT      3
`define AFC_ROUTE_LSB    4
`define AFC_ROUTE_MSB    7
`define AFC_REF_LSB      8
`define AFC_REF_MSB      9
`define AFC_TURBO_BIT    10
`define AFC_PDN_BIT      11
`define AFC_CFG_RST      32'h0000_0000
`define AFC_REF_INT      2'h0
`define AFC_REF_EXT      2'h1
`define AFC_REF_SUP0     2'h2
`define AFC_REF_SUP1     2'h3
`define AFC_GAIN4        3'h2
`define AFC_ROUTE_SE_LO  4'h8
`define AFC_ROUTE_SE_HI  4'hB
`define AFC_CLK_MHZ      40
`define AFC_REF_SETTLE_NS 25000
`define AFC_CLK_NS       25
`define AFC_OSC_NORM_HZ  1024000
`define AFC_OSC_TURBO_HZ 2048000
`define AFC_MCLK_HZ      40000000
`define AFC_PH_W         32
`define AFC_MOD_DIV      2
`define AFC_DEC_RST      16'h0040
`define AFC_STEP_NORM    32'h068D_B8BB
`define AFC_STEP_TURBO   32'h0D1B_7175
`define AFC_SETTLE_ARM   32'hFFFF_FFFF
`define AFC_CFG_MASK     32'h0000_0FFF
`define AFC_RESP_OKAY    2'h0
`define AFC_RESP_SLVERR  2'h2
`endif

// ### verilog/afc_frontend_ctrl.v
// converter front-end control: amplifier bypass, reference, oscillator, decimating filter
`timescale 1ns/10ps
`include "afc_defs.vh"
module afc_frontend_ctrl (
	input  wire        mclk,
	input  wire        sys_rst,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        modBit,
	output reg         oscClk,
	output reg         modulatorRate,
	output wire [2:0]  effGainCode,
	output wire        ampEnable,
	output wire        ampRouteAround,
	output wire [2:0]  scapGainCode,
	output wire        scapBufEnable,
	output wire [1:0]  refSelect,
	output wire        refBufEnable,
	output wire        refSettled,
	output reg  [15:0] sampleData,
	output reg         sampleValid
);
	localparam [31:0] SETTLE_CYC = (`AFC_REF_SETTLE_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS;
	// phase step = 2^32 * fosc / fmclk: accumulator msb is the oscillator square wave
	localparam [31:0] STEP_NORM  = `AFC_STEP_NORM;
	localparam [31:0] STEP_TURBO = `AFC_STEP_TURBO;
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_RUN  = 3'b010;
	localparam [2:0] ST_DONE = 3'b100;

	reg  [31:0] cfg_r;
	reg  [15:0] decim_r;
	reg  [3:0]  awAddr_r;
	reg         awHave_r;
	reg  [31:0] wData_r;
	reg  [3:0]  wStrb_r;
	reg         wHave_r;
	reg  [31:0] settleCnt_r;
	reg  [1:0]  prevRef_r;
	reg         prevPdn_r;
	reg  [31:0] phase_r;
	reg         oscPrev_r;
	reg  [1:0]  modDiv_r;
	reg         modPrev_r;
	reg  [2:0]  state_r;
	reg  [2:0]  state_nxt;
	reg  [15:0] tapIdx_r;
	reg  [31:0] acc_r;
	reg         overrun_r;

	wire [2:0]  gainCode = cfg_r[`AFC_GAIN_MSB:`AFC_GAIN_LSB];
	wire [3:0]  route    = cfg_r[`AFC_ROUTE_MSB:`AFC_ROUTE_LSB];
	wire        bypFlag  = cfg_r[`AFC_BYP_BIT];
	wire        turbo    = cfg_r[`AFC_TURBO_BIT];
	wire        pdn      = cfg_r[`AFC_PDN_BIT];

	// combinational gain path so a config write applies as soon as cfg_r updates
	wire seRoute   = (route >= `AFC_ROUTE_SE_LO) && (route <= `AFC_ROUTE_SE_HI);
	wire lowGain   = (gainCode <= `AFC_GAIN4);
	wire userByp   = bypFlag && lowGain;
	wire forcedByp = seRoute;
	wire anyByp    = userByp || forcedByp;
	// forced bypass cannot reach high gains without the amplifier, so clamp
	wire clampGain = forcedByp && !lowGain;

	assign effGainCode    = clampGain ? `AFC_GAIN4 : gainCode;
	assign ampEnable      = !anyByp;
	assign ampRouteAround = anyByp;
	// scap stage carries gains up to 4; amplifier gives the rest
	assign scapGainCode   = (lowGain || clampGain) ? effGainCode : `AFC_GAIN4;
	assign scapBufEnable  = !ampEnable;

	assign refSelect    = cfg_r[`AFC_REF_MSB:`AFC_REF_LSB];
	assign refBufEnable = (refSelect == `AFC_REF_EXT);
	assign refSettled   = (settleCnt_r == 32'h0000_0000);

	// axi4-lite write: address and data taken in either order
	assign s_axi_awready = !awHave_r && !s_axi_bvalid;
	assign s_axi_wready  = !wHave_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	wire awTake  = s_axi_awvalid && s_axi_awready;
	wire wTake   = s_axi_wvalid && s_axi_wready;
	wire arTake  = s_axi_arvalid && s_axi_arready;
	wire doWrite = awHave_r && wHave_r && !s_axi_bvalid;
	wire wrCfg   = doWrite && (awAddr_r[3:2] == `AFC_ADDR_CFG >> 2);
	wire wrRate  = doWrite && (awAddr_r[3:2] == `AFC_ADDR_RATE >> 2);
	wire wrOk    = doWrite && (awAddr_r[3:2] <= `AFC_ADDR_RATE >> 2);

	// byte-lane merge for both writable words; lanes without a strobe keep old bits
	wire [31:0] rateOld = {16'h0000, decim_r};
	wire [31:0] cfgMerged;
	wire [31:0] rateMerged;
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
			assign cfgMerged[lane*8 +: 8]  = wStrb_r[lane] ? wData_r[lane*8 +: 8] :
			                                 cfg_r[lane*8 +: 8];
			assign rateMerged[lane*8 +: 8] = wStrb_r[lane] ? wData_r[lane*8 +: 8] :
			                                 rateOld[lane*8 +: 8];
		end
	endgenerate
	// a zero ratio would stall the filter, so such a write is dropped
	wire rateZero = (rateMerged[15:0] == 16'h0000);

	// address half held until its data partner arrives
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			awHave_r <= 1'b0;
			awAddr_r <= 4'h0;
		end else if (doWrite) begin
			awHave_r <= 1'b0;
		end else if (awTake) begin
			awHave_r <= 1'b1;
			awAddr_r <= s_axi_awaddr;
		end
	end

	// data half held until its address partner arrives
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wHave_r <= 1'b0;
			wData_r <= 32'h0000_0000;
			wStrb_r <= 4'h0;
		end else if (doWrite) begin
			wHave_r <= 1'b0;
		end else if (wTake) begin
			wHave_r <= 1'b1;
			wData_r <= s_axi_wdata;
			wStrb_r <= s_axi_wstrb;
		end
	end

	// response: unmapped or read-only words answer with an error and change nothing
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `AFC_RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wrOk ? `AFC_RESP_OKAY : `AFC_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			cfg_r <= `AFC_CFG_RST;
		else if (wrCfg)
			cfg_r <= cfgMerged;
	end

	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			decim_r <= `AFC_DEC_RST;
		else if (wrRate && !rateZero)
			decim_r <= rateMerged[15:0];
	end

	wire [31:0] statusWord = {24'h00_0000, overrun_r, refSettled, refBufEnable,
	                          ampRouteAround, ampEnable, effGainCode};

	// read handshake: reads never fail
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= `AFC_RESP_OKAY;
		end else if (arTake) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `AFC_RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// data captured only when an address is taken, so it stands while rvalid does
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rdata <= 32'h0000_0000;
		end else if (arTake) begin
			case (s_axi_araddr[3:2])
				`AFC_ADDR_CFG >> 2:  s_axi_rdata <= cfg_r & `AFC_CFG_MASK;
				`AFC_ADDR_RATE >> 2: s_axi_rdata <= rateOld;
				`AFC_ADDR_STAT >> 2: s_axi_rdata <= statusWord;
				default:             s_axi_rdata <= {16'h0000, sampleData};
			endcase
		end
	end

	// previous-cycle copies for wake and switch-back detection
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			prevRef_r <= `AFC_REF_INT;
			prevPdn_r <= 1'b0;
		end else begin
			prevRef_r <= refSelect;
			prevPdn_r <= pdn;
		end
	end

	wire wakeEvt    = prevPdn_r && !pdn;
	wire switchBack = (prevRef_r != `AFC_REF_INT) && (refSelect == `AFC_REF_INT);

	// timer armed by reset, restarted on wake or switch-back; a restart beats the countdown
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			settleCnt_r <= `AFC_SETTLE_ARM;
		else if (settleCnt_r == `AFC_SETTLE_ARM || wakeEvt || switchBack)
			settleCnt_r <= SETTLE_CYC;
		else if (settleCnt_r != 32'h0000_0000)
			settleCnt_r <= settleCnt_r - 32'h0000_0001;
	end

	wire [31:0] phaseStep = turbo ? STEP_TURBO : STEP_NORM;

	// accumulator halts in power-down; every rate downstream scales with the step
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			phase_r <= 32'h0000_0000;
		else if (!pdn)
			phase_r <= phase_r + phaseStep;
	end

	// edges jitter by one mclk; only the average frequency is exact
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			oscClk    <= 1'b0;
			oscPrev_r <= 1'b0;
		end else begin
			oscClk    <= phase_r[31];
			oscPrev_r <= oscClk;
		end
	end

	wire oscRise = oscClk && !oscPrev_r;

	// divide by four: toggle on every second oscillator rise
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			modDiv_r      <= 2'h0;
			modulatorRate <= 1'b0;
			modPrev_r     <= 1'b0;
		end else begin
			modPrev_r <= modulatorRate;
			if (oscRise) begin
				modDiv_r <= modDiv_r + 2'h1;
				if (modDiv_r[0])
					modulatorRate <= ~modulatorRate;
			end
		end
	end

	wire modTick = modulatorRate && !modPrev_r;
	// a ratio shortened mid-window ends it at the next tick instead of wrapping
	wire windowEnd = modTick && (tapIdx_r >= decim_r - 16'h0001);

	// boxcar FIR over one conversion: linear phase, restarts every output so no history
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (!pdn) state_nxt = ST_RUN;
			ST_RUN: begin
				if (pdn)
					state_nxt = ST_IDLE;
				else if (windowEnd)
					state_nxt = ST_DONE;
			end
			ST_DONE: state_nxt = pdn ? ST_IDLE : ST_RUN;
			default: state_nxt = ST_IDLE;
		endcase
	end

	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// tap counter and running sum of the modulator bits in this window
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tapIdx_r <= 16'h0000;
			acc_r    <= 32'h0000_0000;
		end else begin
			case (state_r)
				ST_RUN: if (modTick) begin
					acc_r    <= acc_r + {31'h0000_0000, modBit};
					tapIdx_r <= tapIdx_r + 16'h0001;
				end
				default: begin
					// fresh window per output: no history, settled after one conversion
					acc_r    <= 32'h0000_0000;
					tapIdx_r <= 16'h0000;
				end
			endcase
		end
	end

	// output word, one-cycle valid and sticky overrun flag
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sampleData  <= 16'h0000;
			sampleValid <= 1'b0;
			overrun_r   <= 1'b0;
		end else begin
			sampleValid <= (state_r == ST_DONE);
			if (state_r == ST_DONE) begin
				sampleData <= acc_r[15:0];
				overrun_r  <= !refSettled || overrun_r;
			end
		end
	end
endmodule // afc_frontend_ctrl
